/* design/hir_params.svh */
`ifndef HIR_PARAMS_SVH
`define HIR_PARAMS_SVH
`define HIR_ADDR_SEL0       7'h5c
`define HIR_ADDR_SEL1       7'h5d
`define HIR_MAX_RATE_KBPS   400
`define HIR_SUBADDR_RST     8'h00
`define HIR_BYTE_BITS       4'h8
`endif

/* design/hir_pkg.sv */
package hir_pkg;
    typedef enum logic [2:0] {
        HIR_IDLE  = 3'b000,
        HIR_ADDR  = 3'b001,
        HIR_WACK  = 3'b010,
        HIR_WRX   = 3'b011,
        HIR_TX    = 3'b100,
        HIR_RACK  = 3'b101,
        HIR_SKIP  = 3'b110
    } hir_state_t;
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } hir_wr_t;
endpackage : hir_pkg

/* design/hir_slave.sv */
`timescale 1ns/100ps
`include "hir_params.svh"
module hir_slave (
    input  wire logic           clk,         // 25 MHz core clock
    input  wire logic           nrst,        // Synchronous reset, active low
    input  wire logic           bus_address_select, // Address strap
    input  wire logic           scl_in,      // Serial clock pin level
    input  wire logic           sda_in,      // Serial data pin level
    output logic                scl_out,     // Serial clock drive value
    output logic                scl_oe_n,    // Clock pull-low enable, low drives
    output logic                sda_out,     // Serial data drive value
    output logic                sda_oe_n,    // Data pull-low enable, low drives
    output hir_pkg::hir_wr_t    reg_wr,      // Register write strobe bundle
    input  wire logic [7:0]     reg_rdata,   // Register read data for reg_raddr
    output logic      [7:0]     reg_raddr    // Register read address
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one is read only by stage two.
    logic [1:0] scl_s_r, sda_s_r, sel_s_r;
    logic       scl_d_r, sda_d_r;
    always_ff @(posedge clk) begin
        scl_s_r <= {scl_s_r[0], scl_in};
        sda_s_r <= {sda_s_r[0], sda_in};
        sel_s_r <= {sel_s_r[0], bus_address_select};
        scl_d_r <= scl_s_r[1];
        sda_d_r <= sda_s_r[1];
    end
    wire scl    = scl_s_r[1];
    wire sda    = sda_s_r[1];
    wire scl_rise = scl & ~scl_d_r;
    wire scl_fall = ~scl & scl_d_r;
    wire start_c  = scl & scl_d_r & sda_d_r & ~sda;
    wire stop_c   = scl & scl_d_r & ~sda_d_r & sda;

    ////////////////////////////////////////////////////////////////////////
    // The strap is caught on the first clock edge after reset release.
    logic       in_rst_r, sel_r, sel_nxt;
    always_comb begin
        sel_nxt = sel_r;
        if (in_rst_r)
            sel_nxt = sel_s_r[1];
    end
    always_ff @(posedge clk) begin
        in_rst_r <= ~nrst;
        sel_r    <= nrst ? sel_nxt : 1'b0;
    end

    function automatic logic [6:0] my_addr(input logic s);
        my_addr = s ? `HIR_ADDR_SEL1 : `HIR_ADDR_SEL0;
    endfunction : my_addr

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine. Bits are taken on rising clock, drive changes on falling.
    hir_pkg::hir_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic       sub_r, sub_nxt;        // Next write byte is the subaddress.
    logic [7:0] ptr_r, ptr_nxt;
    logic       drv_r, drv_nxt;        // 1 means pull data low.
    logic       rd_r, rd_nxt;
    hir_pkg::hir_wr_t wr_r, wr_nxt;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        sh_nxt  = sh_r;
        sub_nxt = sub_r;
        ptr_nxt = ptr_r;
        drv_nxt = drv_r;
        rd_nxt  = rd_r;
        wr_nxt  = '0;
        if (start_c) begin
            st_nxt  = hir_pkg::HIR_ADDR;
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt  = hir_pkg::HIR_IDLE;
            drv_nxt = 1'b0;
        end else begin
            case (st_r)
                hir_pkg::HIR_IDLE, hir_pkg::HIR_SKIP: begin
                    drv_nxt = 1'b0;
                end
                hir_pkg::HIR_ADDR, hir_pkg::HIR_WRX: begin
                    if (scl_rise) begin
                        sh_nxt  = {sh_r[6:0], sda};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == `HIR_BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        if (st_r == hir_pkg::HIR_ADDR) begin
                            if (sh_r[7:1] == my_addr(sel_r)) begin
                                drv_nxt = 1'b1;
                                rd_nxt  = sh_r[0];
                                sub_nxt = ~sh_r[0];
                                st_nxt  = hir_pkg::HIR_WACK;
                            end else begin
                                st_nxt  = hir_pkg::HIR_SKIP;
                            end
                        end else begin
                            drv_nxt = 1'b1;
                            st_nxt  = hir_pkg::HIR_WACK;
                            if (sub_r) begin
                                ptr_nxt = sh_r;
                                sub_nxt = 1'b0;
                            end else begin
                                wr_nxt  = '{we: 1'b1, addr: ptr_r, data: sh_r};
                                ptr_nxt = ptr_r + 8'h01;
                            end
                        end
                    end
                end
                hir_pkg::HIR_WACK: begin
                    if (scl_fall) begin
                        if (rd_r) begin
                            drv_nxt = ~reg_rdata[7];
                            sh_nxt  = {reg_rdata[6:0], 1'b0};
                            ptr_nxt = ptr_r + 8'h01;
                            cnt_nxt = 4'h1;
                            st_nxt  = hir_pkg::HIR_TX;
                        end else begin
                            drv_nxt = 1'b0;
                            st_nxt  = hir_pkg::HIR_WRX;
                        end
                    end
                end
                hir_pkg::HIR_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == `HIR_BYTE_BITS) begin
                            drv_nxt = 1'b0;
                            st_nxt  = hir_pkg::HIR_RACK;
                        end else begin
                            drv_nxt = ~sh_r[7];
                            sh_nxt  = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                hir_pkg::HIR_RACK: begin
                    if (scl_rise)
                        st_nxt = sda ? hir_pkg::HIR_SKIP : hir_pkg::HIR_WACK;
                end
                default: st_nxt = hir_pkg::HIR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r  <= hir_pkg::HIR_IDLE;
            cnt_r <= 4'h0;
            sh_r  <= 8'h00;
            sub_r <= 1'b0;
            ptr_r <= `HIR_SUBADDR_RST;
            drv_r <= 1'b0;
            rd_r  <= 1'b0;
            wr_r  <= '0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r  <= sh_nxt;
            sub_r <= sub_nxt;
            ptr_r <= ptr_nxt;
            drv_r <= drv_nxt;
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. The clock pin is never pulled; a target does not stretch here.
    always_ff @(posedge clk) begin
        scl_out   <= 1'b0;
        scl_oe_n  <= 1'b1;
        sda_out   <= 1'b0;
        sda_oe_n  <= ~(nrst & drv_nxt);
        reg_wr    <= nrst ? wr_nxt : '0;
        reg_raddr <= nrst ? ptr_nxt : `HIR_SUBADDR_RST;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_ack_byte;
        (st_r == hir_pkg::HIR_WRX) && scl_fall && cnt_r == 4'h8;
    endsequence
    a_clk_released: assert property (@(posedge clk) disable iff (!nrst) ##1 scl_oe_n)
        else $error("clock pin driven");
    a_sda_od: assert property (@(posedge clk) disable iff (!nrst) sda_out == 1'b0)
        else $error("data pin driven high");
    a_strap_held: assert property (@(posedge clk) disable iff (!nrst)
        !in_rst_r |=> $stable(sel_r))
        else $error("address choice changed");
    a_byte_acked: assert property (@(posedge clk) disable iff (!nrst)
        (s_ack_byte and (!start_c && !stop_c)) |-> ##2 !sda_oe_n)
        else $error("byte not acknowledged");
    a_start_resets: assert property (@(posedge clk) disable iff (!nrst)
        start_c |=> st_r == hir_pkg::HIR_ADDR && cnt_r == 4'h0)
        else $error("start not taken");
    a_stop_idles: assert property (@(posedge clk) disable iff (!nrst)
        stop_c |=> st_r == hir_pkg::HIR_IDLE ##1 sda_oe_n)
        else $error("stop not taken");
    a_skip_quiet: assert property (@(posedge clk) disable iff (!nrst)
        st_r == hir_pkg::HIR_SKIP |=> sda_oe_n)
        else $error("drive while ignoring bus");
    a_nack_release: assert property (@(posedge clk) disable iff (!nrst)
        st_r == hir_pkg::HIR_RACK && scl_rise && sda && !start_c && !stop_c
        |=> st_r == hir_pkg::HIR_SKIP)
        else $error("nack not honoured");
    a_write_inc: assert property (@(posedge clk) disable iff (!nrst)
        wr_nxt.we |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer not advanced");
endmodule : hir_slave

/* sim/hir_host_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural bus master; both lines are only ever released or pulled low.
module hir_host_model #(
    // Quarter bit time; a 320 ns bit leaves the core its four clocks of high and of low.
    parameter int Q = 80
) (
    output logic     scl_rel, // Clock released when high
    output logic     sda_rel, // Data released when high
    input wire logic sda      // Resolved data line
);
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    // Data moves a quarter bit after the clock fall; the target's own change follows in the same low phase.
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        #Q scl_rel = 1'b1;
        #Q s = sda;
        #Q scl_rel = 1'b0;
        #Q;
    endtask : bit_io
    task automatic start_c();
        sda_rel = 1'b1;
        scl_rel = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl_rel = 1'b0;
        #Q;
    endtask : start_c
    task automatic stop_c();
        sda_rel = 1'b0;
        #Q scl_rel = 1'b1;
        #Q sda_rel = 1'b1;
        #Q;
    endtask : stop_c
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s; // An unknown level stays unknown and fails the check.
    endtask : wbyte
    task automatic rbyte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~give_ack, s);
    endtask : rbyte
endmodule : hir_host_model

/* sim/test_host_i2c_register_slave.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
////////////////////////////////////////////////////////////////////////////////
module test_host_i2c_register_slave;
    logic clk, nrst, sel, scl_in, sda_in, scl_out, scl_oe_n, sda_out, sda_oe_n, scl_rel, sda_rel, a;
    logic [7:0] reg_raddr, d;
    logic [7:0] mem [256];
    hir_pkg::hir_wr_t reg_wr;
    int num_errors = 0, n_checks = 0, wr_cnt = 0;
    wire scl_w = scl_rel & (scl_oe_n | scl_out);
    wire sda_w = sda_rel & (sda_oe_n | sda_out);
    hir_host_model host (.scl_rel(scl_rel), .sda_rel(sda_rel), .sda(sda_w));
    hir_slave uut (.clk(clk), .nrst(nrst), .bus_address_select(sel), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .reg_wr(reg_wr), .reg_rdata(mem[reg_raddr]), .reg_raddr(reg_raddr));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Pin levels are handed over on the falling edge so the core never races the bench.
    always @(negedge clk) begin
        scl_in <= scl_w;
        sda_in <= sda_w;
    end
    always @(posedge clk) if (nrst === 1'b1) begin
        `CHK("scl_oe_n", 1'b1, scl_oe_n)
        `CHK("scl_out", 1'b0, scl_out)
        if (sda_oe_n === 1'b0) `CHK("sda_out", 1'b0, sda_out)
        if (reg_wr.we === 1'b1) begin
            mem[reg_wr.addr] <= reg_wr.data;
            wr_cnt++;
        end
    end
    task automatic end_sim();
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic do_reset(input logic s);
        @(negedge clk);
        sel = s;
        nrst = 1'b0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        // The strap drops once captured, so the held address choice is exercised.
        sel = 1'b0;
        // Model events sit off the falling edge so the pin handover never races them.
        #5;
    endtask : do_reset
    task automatic t_write();
        logic [7:0] v [3] = '{8'ha5, 8'h3c, 8'h81};
        do_reset(1'b0);
        host.start_c();
        host.wbyte(8'hb8, a);
        `CHK("addr ack", 1'b1, a)
        host.wbyte(8'hfe, a);
        `CHK("sub ack", 1'b1, a)
        for (int k = 0; k < 3; k++) begin
            host.wbyte(v[k], a);
            `CHK("data ack", 1'b1, a)
        end
        host.stop_c();
        for (int k = 0; k < 3; k++) `CHK("mem", v[k], mem[8'(8'hfe + k)])
    endtask : t_write
    task automatic t_read();
        logic [7:0] v [3] = '{8'ha5, 8'h3c, 8'h81};
        host.start_c();
        host.wbyte(8'hb8, a);
        host.wbyte(8'hfe, a);
        host.stop_c();
        host.start_c();
        host.wbyte(8'hb9, a);
        `CHK("read addr ack", 1'b1, a)
        for (int k = 0; k < 3; k++) begin
            host.rbyte(k < 2, d);
            `CHK("read data", v[k], d)
        end
        `CHK("released after nack", 1'b1, sda_oe_n)
        host.stop_c();
    endtask : t_read
    task automatic t_foreign();
        int n;
        n = wr_cnt;
        host.start_c();
        host.wbyte(8'hba, a);
        `CHK("foreign nack", 1'b0, a)
        host.wbyte(8'h20, a);
        `CHK("ignored byte", 1'b0, a)
        host.stop_c();
        `CHK("no write", n, wr_cnt)
    endtask : t_foreign
    task automatic t_strap();
        do_reset(1'b1);
        host.start_c();
        host.wbyte(8'hb8, a);
        `CHK("old addr nack", 1'b0, a)
        host.stop_c();
        host.start_c();
        host.wbyte(8'hba, a);
        `CHK("strap held", 1'b1, a)
        host.wbyte(8'h40, a);
        host.wbyte(8'h77, a);
        host.stop_c();
        `CHK("strap write", 8'h77, mem[8'h40])
    endtask : t_strap
    initial begin
        sel = 1'b0;
        nrst = 1'b0;
        scl_in = 1'b1;
        sda_in = 1'b1;
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        t_write();
        t_read();
        t_foreign();
        t_strap();
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : test_host_i2c_register_slave
